// ---- bench/ssr_host.sv ----
`timescale 1ns/1ps
module ssr_host (
  // clock
  input  wire logic clk,
  // device and host sides of the serial pin
  input  wire logic dev_o,
  input  wire logic dev_oe,
  input  wire logic host_o,
  input  wire logic host_oe,
  // resolved wire
  output logic      pin
);
  logic last_q = 1'b0;
  // undriven line must not echo the last level
  always_comb pin = dev_oe ? dev_o : (host_oe ? host_o : ~last_q);
  always_ff @(posedge clk)
    if (dev_oe | host_oe)
      last_q <= pin;
endmodule

// ---- bench/testbench.sv ----
`timescale 1ns/1ps
module testbench;
  logic        mclk = 1'b0;
  logic        rst = 1'b1;
  logic        cs_n = 1'b1;
  logic        rd_wr = 1'b0;
  logic        sh = 1'b0;
  logic        md = 1'b0;
  logic        clr_n = 1'b1;
  logic        h_o = 1'b0;
  logic        h_oe = 1'b0;
  logic        pin;
  logic        so;
  logic        soe;
  logic [15:0] pout;
  int          failures = 0;
  int          n_tests = 0;
  always #10 mclk = ~mclk;
  ssr_shift_store i_ssr_shift_store (
    .MCLK(mclk), .RST(rst), .CS_N(cs_n), .RD_WR(rd_wr), .SHIFT_STROBE(sh),
    .MODE_OR_STORE_STROBE(md), .STORAGE_CLEAR_N(clr_n), .SERIAL_IO_PIN_I(pin),
    .SERIAL_IO_PIN_O(so), .SERIAL_IO_PIN_OE(soe), .PARALLEL_OUT_BIT(pout));
  ssr_host i_ssr_host (.clk(mclk), .dev_o(so), .dev_oe(soe), .host_o(h_o),
    .host_oe(h_oe), .pin(pin));
  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      failures++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  // cs_n, rd_wr, shift, mode, host enable, host data; held past sync latency
  task automatic drv(input logic [5:0] v);
    @(posedge mclk);
    {cs_n, rd_wr, sh, md, h_oe, h_o} <= v;
    repeat (5) @(posedge mclk);
    #1;
  endtask
  task automatic wr_word(input logic [15:0] w);
    for (int i = 15; i >= 0; i--)
    begin
      drv({4'b0010, 1'b1, w[i]});
      drv({4'b0000, 1'b1, w[i]});
    end
  endtask
  task automatic rd_word(input logic [15:0] w);
    for (int i = 15; i >= 0; i--)
    begin
      cmp(pin, w[i]);
      drv(6'b011000);
      drv(6'b010000);
    end
  endtask
  task automatic test_done;
    $display("checks %0d, mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  initial
  begin
    #200000;
    failures++;
    test_done();
  end
  initial
  begin
    repeat (3) @(posedge mclk);
    rst <= 1'b0;
    drv(6'b100000);
    cmp(pout, 16'h0000);
    cmp(soe, 1'b0);
    drv(6'b000000);
    wr_word(16'ha5c3);
    cmp(soe, 1'b0);
    drv(6'b000100);
    cmp(pout, 16'ha5c3);
    drv(6'b000000);
    drv(6'b010000);
    cmp(soe, 1'b1);
    rd_word(16'ha5c3);
    rd_word(16'ha5c3);
    drv(6'b000000);
    wr_word(16'h3c96);
    drv(6'b100000);
    cmp(soe, 1'b0);
    drv(6'b101000);
    drv(6'b100100);
    cmp(pout, 16'ha5c3);
    drv(6'b100000);
    drv(6'b000000);
    drv(6'b010000);
    rd_word(16'h3c96);
    drv(6'b010100);
    drv(6'b011100);
    drv(6'b010100);
    drv(6'b010000);
    rd_word(16'ha5c3);
    drv(6'b110000);
    cmp(soe, 1'b0);
    @(posedge mclk);
    clr_n <= 1'b0;
    #1;
    cmp(pout, 16'h0000);
    repeat (2) @(posedge mclk);
    #1;
    cmp(pout, 16'h0000);
    test_done();
  end
endmodule

// ---- hdl/ssr_pkg.sv ----
package ssr_pkg;

  // register geometry and reset values
  localparam int          SR_WIDTH     = 16;
  localparam logic [15:0] SHIFT_RST    = 16'h0000;
  localparam logic [15:0] STORE_RST    = 16'h0000;
  // flip-flops between a pin and the first logic that reads it
  localparam int          SYNC_STAGES  = 2;
  localparam int          CTRL_BITS    = 5;

  // pin levels after synchronisation, all in the MCLK domain
  typedef struct packed {
    logic cs_n;
    logic rd_wr;
    logic shift_strobe;
    logic mode_or_store_strobe;
    logic serial_in;
  } ssr_ctrl_t;

  // what the serial pin does in a given cycle
  typedef struct packed {
    logic drive;
    logic level;
  } ssr_pin_t;

endpackage

// ---- hdl/ssr_shift_store.sv ----
`timescale 1ns/1ps
// How it works
// (R1) sixteen-bit shift and storage registers together
// (R2) one three-state pin for serial in/out
// (R3) storage clear low clears storage immediately
// (R4) store strobe copies shift register into storage
// (R5) storage register drives the parallel outputs
// (R6) parallel load copies storage into shift register
// (R7) chip select high ignores both strobes
// (R8) chip select high releases the serial pin
// (R9) storage clear works regardless of chip select
// (R10) host keeps shift strobe low raising select
// (R11) host keeps store strobe low dropping select
// (R12) each shift moves bits toward the MSB
module ssr_shift_store #(
  parameter int WIDTH = ssr_pkg::SR_WIDTH
) (
  // clock and reset
  input  wire logic             MCLK,
  input  wire logic             RST,
  // control pins, all asynchronous to MCLK
  input  wire logic             CS_N,
  input  wire logic             RD_WR,
  input  wire logic             SHIFT_STROBE,
  input  wire logic             MODE_OR_STORE_STROBE,
  input  wire logic             STORAGE_CLEAR_N,
  // serial pin, split into its three signals
  input  wire logic             SERIAL_IO_PIN_I,
  output logic                  SERIAL_IO_PIN_O,
  output logic                  SERIAL_IO_PIN_OE,
  // parallel outputs
  output logic [WIDTH-1:0]      PARALLEL_OUT_BIT
);

  initial
  begin
    if (WIDTH != ssr_pkg::SR_WIDTH)
      $error("ssr_shift_store supports only the documented width");
  end

  ssr_pkg::ssr_ctrl_t ctrl_s;
  logic               shift_prev_q;
  logic               store_prev_q;
  logic               shift_fall;
  logic               store_rise;
  logic [WIDTH-1:0]   shift_q;
  logic [WIDTH-1:0]   shift_d;
  logic [WIDTH-1:0]   store_q;
  ssr_pkg::ssr_pin_t  pin_q;
  ssr_pkg::ssr_pin_t  pin_d;

  ssr_sync #(
    .W      (ssr_pkg::CTRL_BITS),
    .STAGES (ssr_pkg::SYNC_STAGES)
  ) u_sync (
    .clk     (MCLK),
    .rst     (RST),
    .async_i ({CS_N, RD_WR, SHIFT_STROBE, MODE_OR_STORE_STROBE, SERIAL_IO_PIN_I}),
    .sync_o  (ctrl_s)
  );

  // previous synchronised strobe levels for edge detection
  always_ff @(posedge MCLK)
  begin
    if (RST)
    begin
      shift_prev_q <= 1'b0;
      store_prev_q <= 1'b0;
    end
    else
    begin
      shift_prev_q <= ctrl_s.shift_strobe;
      store_prev_q <= ctrl_s.mode_or_store_strobe;
    end
  end

  // strobes count only with select low; a select change alone is no edge,
  // so the host's care around select transitions is not needed here
  assign shift_fall = shift_prev_q & ~ctrl_s.shift_strobe & ~ctrl_s.cs_n; // (R7) (R10)
  assign store_rise = ~store_prev_q & ctrl_s.mode_or_store_strobe & ~ctrl_s.cs_n
                      & ~ctrl_s.rd_wr; // (R7) (R11)

  // one stage toward the MSB, the new bit enters at bit 0
  function automatic logic [WIDTH-1:0] step_up(input logic [WIDTH-1:0] word,
                                               input logic             bit_in);
    return {word[WIDTH-2:0], bit_in};
  endfunction

  // shift register next value
  always_comb
  begin
    shift_d = shift_q;
    if (shift_fall)
    begin
      if (!ctrl_s.rd_wr)
        shift_d = step_up(shift_q, ctrl_s.serial_in); // (R2) (R12)
      else if (!ctrl_s.mode_or_store_strobe)
        shift_d = step_up(shift_q, shift_q[WIDTH-1]); // (R12)
      else
        shift_d = store_q; // (R6)
    end
  end

  always_ff @(posedge MCLK)
  begin
    if (RST)
      shift_q <= ssr_pkg::SHIFT_RST;
    else
      shift_q <= shift_d; // (R1)
  end

  // clear acts without the clock and whatever the select level;
  // its release is not synchronised, so keep it away from a store edge
  always_ff @(posedge MCLK or negedge STORAGE_CLEAR_N)
  begin
    if (!STORAGE_CLEAR_N)
      store_q <= ssr_pkg::STORE_RST; // (R3) (R9)
    else if (RST)
      store_q <= ssr_pkg::STORE_RST;
    else if (store_rise)
      store_q <= shift_q; // (R4)
  end

  assign PARALLEL_OUT_BIT = store_q; // (R5)

  // pin drives in read mode only; level is the MSB after any shift
  always_comb
  begin
    pin_d.drive = ~ctrl_s.cs_n & ctrl_s.rd_wr; // (R8)
    pin_d.level = shift_d[WIDTH-1]; // (R2)
  end

  always_ff @(posedge MCLK)
  begin
    if (RST)
      pin_q <= '0;
    else
      pin_q <= pin_d;
  end

  assign SERIAL_IO_PIN_OE = pin_q.drive;
  assign SERIAL_IO_PIN_O  = pin_q.level & pin_q.drive;

  // checks
  a_clear_empties: assert property (@(posedge MCLK) // (R3)
    !STORAGE_CLEAR_N |-> PARALLEL_OUT_BIT == '0)
    else $error("storage not clear while clear is low");

  a_store_copies: assert property (@(posedge MCLK) disable iff (RST) // (R4)
    store_rise && STORAGE_CLEAR_N |=> PARALLEL_OUT_BIT == $past(shift_q))
    else $error("store strobe did not copy shift register");

  a_load_copies: assert property (@(posedge MCLK) disable iff (RST) // (R6)
    shift_fall && ctrl_s.rd_wr && ctrl_s.mode_or_store_strobe
    |=> shift_q == $past(store_q))
    else $error("parallel load did not copy storage");

  a_write_shift: assert property (@(posedge MCLK) disable iff (RST) // (R12)
    shift_fall && !ctrl_s.rd_wr
    |=> shift_q == {$past(shift_q[WIDTH-2:0]), $past(ctrl_s.serial_in)})
    else $error("serial write shift wrong");

  a_read_rotate: assert property (@(posedge MCLK) disable iff (RST) // (R2)
    shift_fall && ctrl_s.rd_wr && !ctrl_s.mode_or_store_strobe
    |=> SERIAL_IO_PIN_O == $past(shift_q[WIDTH-2]))
    else $error("read did not present next bit");

  a_select_holds: assert property (@(posedge MCLK) disable iff (RST) // (R7)
    ctrl_s.cs_n && STORAGE_CLEAR_N ##1 STORAGE_CLEAR_N
    |-> $stable(shift_q) && $stable(PARALLEL_OUT_BIT))
    else $error("registers changed while deselected");

  a_select_release: assert property (@(posedge MCLK) disable iff (RST) // (R8)
    ctrl_s.cs_n |=> !SERIAL_IO_PIN_OE)
    else $error("pin driven while deselected");

  a_write_release: assert property (@(posedge MCLK) disable iff (RST) // (R2)
    !ctrl_s.rd_wr |=> !SERIAL_IO_PIN_OE)
    else $error("pin driven in write mode");

  a_outputs_follow: assert property (@(posedge MCLK) disable iff (RST) // (R5)
    !store_rise && STORAGE_CLEAR_N ##1 STORAGE_CLEAR_N |-> $stable(PARALLEL_OUT_BIT))
    else $error("outputs moved without a store");

  a_reset_empties: assert property (@(posedge MCLK) // (R1)
    RST |=> shift_q == ssr_pkg::SHIFT_RST && !SERIAL_IO_PIN_OE)
    else $error("shift register not reset");

  a_read_drives: assert property (@(posedge MCLK) disable iff (RST) // (R2)
    !ctrl_s.cs_n && ctrl_s.rd_wr |=> SERIAL_IO_PIN_OE)
    else $error("pin not driven in read mode");

  a_read_presents: assert property (@(posedge MCLK) disable iff (RST) // (R2)
    !ctrl_s.cs_n && ctrl_s.rd_wr && !shift_fall
    |=> SERIAL_IO_PIN_O == $past(shift_q[WIDTH-1]))
    else $error("read pin does not show the top bit");

  a_pin_quiet: assert property (@(posedge MCLK) disable iff (RST) // (R8)
    !SERIAL_IO_PIN_OE |-> !SERIAL_IO_PIN_O)
    else $error("pin level up while released");

  a_shift_idle: assert property (@(posedge MCLK) disable iff (RST) // (R12)
    !shift_fall |=> $stable(shift_q))
    else $error("shift register moved without a shift");

  a_load_keeps_store: assert property (@(posedge MCLK) disable iff (RST) // (R6)
    ctrl_s.rd_wr && STORAGE_CLEAR_N ##1 STORAGE_CLEAR_N |-> $stable(PARALLEL_OUT_BIT))
    else $error("storage changed in read mode");

  a_deselect_no_edge: assert property (@(posedge MCLK) disable iff (RST) // (R7)
    ctrl_s.cs_n |-> !shift_fall && !store_rise)
    else $error("strobe taken while deselected");

  a_clear_deselected: assert property (@(posedge MCLK) // (R9)
    !STORAGE_CLEAR_N && ctrl_s.cs_n |-> PARALLEL_OUT_BIT == '0)
    else $error("clear blocked by select");

endmodule

// ---- hdl/ssr_sync.sv ----
`timescale 1ns/1ps
module ssr_sync #(
  parameter int W      = 1,
  parameter int STAGES = ssr_pkg::SYNC_STAGES
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         rst,
  // asynchronous levels in, synchronised levels out
  input  wire logic [W-1:0] async_i,
  output logic      [W-1:0] sync_o
);

  logic [W-1:0] stage_q [STAGES];

  initial
  begin
    if (STAGES < 2)
      $error("ssr_sync needs at least two stages");
  end

  // first stage is read only by the next stage
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      for (int i = 0; i < STAGES; i++)
        stage_q[i] <= '0;
    end
    else
    begin
      stage_q[0] <= async_i;
      for (int i = 1; i < STAGES; i++)
        stage_q[i] <= stage_q[i-1];
    end
  end

  assign sync_o = stage_q[STAGES-1];

endmodule
